// File: logic/ecpl_fifo.sv
// Shared FIFO of 9-bit words (byte plus tag bit) with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ecpl_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
    $error("FIFO depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;

  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW] != rd_ptr[AW]) &&
                (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

// File: logic/ecpl_port.sv
// Extended-capabilities parallel port: registers, FIFO views, link engine
// Rules of the port and its peripheral
// R1 - Every link word is one byte, same as the host data path.
// R2 - One sixteen-byte FIFO serves all FIFO views in both directions.
// R3 - Compatibility FIFO mode runs strobe and busy handshake in hardware.
// R4 - Run-length count byte is swallowed; the next byte is repeated.
// R5 - Hardware compression is optional and not provided here.
// R6 - Select-in stays deasserted throughout protocol mode.
// R7 - Forward: byte on data lines, strobe asserted, interlocked with busy.
// R8 - Peripheral drops busy when it can take another byte.
// R9 - Forward: host flow line marks address/command versus data.
// R10 - Reverse: host flow line asserted requests a byte, interlocked.
// R11 - Peripheral clock asserted means reverse byte on data lines valid.
// R12 - Reverse: busy line tags command or data; captured with each byte.
// R13 - Reverse-request line low selects reverse, high forward.
// R14 - Peripheral acknowledges reverse request by pulling reverse ack low.
// R15 - Data lines stay undriven until reverse ack shows forward again.
// R16 - Peripheral drives data only in protocol, flow low, select-in high.
// R17 - Peripheral request asserted in forward raises error indication.
// R18 - Peripheral request is only a hint; host keeps direction control.
// R19 - Status, control and extended control reachable in every mode.
// R20 - Config B reflects configured interrupt line and DMA channel.
// R21 - Extended control mode field selects register views and behaviour.
// R22 - Direction bit: 1 input, 0 output; ignored in modes 000 and 010.
// R23 - Address FIFO byte bit 7: 1 channel address, 0 run-length count.
// R24 - Config A reads only bit 4 set; extended control bit layout fixed.
`timescale 1ns/1ps
`default_nettype none
module ecpl_port
  import ecpl_pkg::*;
#(
  parameter int FIFO_DEPTH = ECPL_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [10:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] cfg_irq_select,
  input wire logic [2:0] cfg_dma_select,
  input wire logic interrupt_line_level,
  input wire logic [7:0] pd_in,
  output logic [7:0] pd_out,
  output logic pd_oe_n,
  output logic host_clock_strobe,
  output logic host_flow_line,
  output logic reverse_request_line,
  output logic select_in_line,
  input wire logic periph_clock_line,
  input wire logic periph_flow_line,
  input wire logic reverse_acknowledge_line,
  input wire logic peripheral_request_line,
  input wire logic select_status_line,
  output logic error_interrupt
);
  if (FIFO_DEPTH != ECPL_FIFO_DEPTH) begin : g_bad_depth
    $error("The shared FIFO must hold sixteen bytes");
  end

  typedef enum logic [2:0] {
    LK_IDLE,
    LK_SETUP,
    LK_STROBE,
    LK_REV_TURN,
    LK_REV_WAIT,
    LK_REV_DONE,
    LK_FWD_TURN
  } ecpl_link_state_type;

  ecpl_link_state_type link_state;

  logic [IN_BITS-1:0] raw_in;
  logic [IN_BITS-1:0] sync_a;
  logic [IN_BITS-1:0] sync_b;
  logic [IN_BITS-1:0] sync_c;
  logic [IN_BITS-1:0] pin_in;

  logic [7:0] data_latch;
  logic [5:0] control;
  logic [2:0] mode;
  logic dma_request_enable;
  logic service_interrupt_flag;
  logic [7:0] last_read;

  logic [7:0] link_byte;
  logic strobe_n;
  logic flow_n;
  logic init_n;
  logic reversed;
  logic [7:0] setup_cnt;
  logic [6:0] rle_count;
  logic rle_pending;
  logic [7:0] rep_left;
  logic [8:0] push_word;

  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [8:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [8:0] fifo_out_data;
  logic fifo_full;
  logic fifo_empty;
  logic fifo_flush;

  logic dir_in;
  logic proto_mode;
  logic fwd_engine;
  logic host_push;
  logic host_pop;
  logic eng_pop;
  logic [8:0] host_word;
  logic ecr_write;

  // Three-stage input synchroniser; a change counts when stages agree
  assign raw_in = {select_status_line, peripheral_request_line,
                   reverse_acknowledge_line, periph_flow_line,
                   periph_clock_line, pd_in};

  for (genvar g = 0; g < IN_BITS; g++) begin : g_sync
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        sync_a[g] <= PIN_IN_RESET[g];
        sync_b[g] <= PIN_IN_RESET[g];
        sync_c[g] <= PIN_IN_RESET[g];
        pin_in[g] <= PIN_IN_RESET[g];
      end else begin
        sync_a[g] <= raw_in[g];
        sync_b[g] <= sync_a[g];
        sync_c[g] <= sync_b[g];
        if (sync_b[g] == sync_c[g]) begin
          pin_in[g] <= sync_c[g];
        end
      end
    end
  end

  // Mode and direction decode
  assign dir_in = control[CTL_DIR_BIT] &&
                  (mode != MODE_STANDARD) &&
                  (mode != MODE_COMPAT_FIFO); // R22
  assign proto_mode = (mode == MODE_PROTOCOL); // R21
  assign fwd_engine = (mode == MODE_COMPAT_FIFO) ||
                      (proto_mode && !dir_in && !reversed); // R3 R21

  // Host accesses into the shared FIFO views
  assign ecr_write = reg_wr && (reg_addr == OFS_EXT_CONTROL);
  assign fifo_flush = ecr_write &&
    (reg_wdata[7:ECR_MODE_LSB] == MODE_STANDARD ||
     reg_wdata[7:ECR_MODE_LSB] == MODE_BIDIR);

  always_comb begin
    host_push = 1'b0;
    host_word = {1'b0, reg_wdata};
    if (reg_wr && reg_addr == OFS_DATA && proto_mode && !dir_in) begin
      host_push = 1'b1; // R23
      host_word = {1'b1, reg_wdata};
    end else if (reg_wr && reg_addr == OFS_FIFO) begin
      host_push = (mode == MODE_COMPAT_FIFO) || (mode == MODE_TEST) ||
                  (proto_mode && !dir_in); // R2
    end
  end

  assign host_pop = reg_rd && (reg_addr == OFS_FIFO) &&
                    ((mode == MODE_TEST) || (proto_mode && dir_in));
  assign eng_pop = (link_state == LK_IDLE) && fwd_engine && fifo_out_valid;

  assign fifo_in_valid = reversed ? (rep_left != 8'h00) : host_push;
  assign fifo_in_data = reversed ? push_word : host_word;
  assign fifo_out_ready = eng_pop || host_pop;

  ecpl_fifo #(
    .WIDTH(ECPL_WORD_BITS + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .flush(fifo_flush),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .full(fifo_full),
    .empty(fifo_empty)
  ); // R2

  // Software-visible control state
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      data_latch <= DATA_RESET;
      control <= CONTROL_RESET;
    end else if (reg_wr) begin
      if (reg_addr == OFS_DATA &&
          (mode == MODE_STANDARD || mode == MODE_BIDIR)) begin
        data_latch <= reg_wdata;
      end
      if (reg_addr == OFS_CONTROL) begin
        control <= reg_wdata[5:0]; // R19
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode <= MODE_RESET;
      dma_request_enable <= 1'b0;
    end else if (ecr_write) begin
      mode <= reg_wdata[7:ECR_MODE_LSB]; // R21
      dma_request_enable <= reg_wdata[ECR_DMA_BIT];
    end
  end

  // Service flag: hardware set wins over a software clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      service_interrupt_flag <= 1'b0;
    end else if (!dma_request_enable &&
                 ((!dir_in && fifo_empty) || (dir_in && fifo_full))) begin
      service_interrupt_flag <= 1'b1;
    end else if (ecr_write) begin
      service_interrupt_flag <= reg_wdata[ECR_SERVICE_BIT];
    end
  end

  // Register read port; an empty FIFO re-reads the last byte
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      last_read <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_DATA: begin
          reg_rdata <= proto_mode ? 8'h00 : pin_in[7:0];
        end
        OFS_STATUS: begin
          reg_rdata <= {~pin_in[IN_BUSY], pin_in[IN_PERIPH_CLOCK_LINE],
                        pin_in[IN_REVERSE_ACKNOWLEDGE_LINE], pin_in[IN_SELECT],
                        pin_in[IN_FAULT], 3'h0}; // R19
        end
        OFS_CONTROL: begin
          reg_rdata <= {2'h0, control}; // R19
        end
        OFS_FIFO: begin
          if (mode == MODE_CONFIG) begin
            reg_rdata <= CONFIG_A_VALUE; // R24
          end else if (host_pop && fifo_out_valid) begin
            reg_rdata <= fifo_out_data[7:0];
            last_read <= fifo_out_data[7:0];
          end else begin
            reg_rdata <= last_read;
          end
        end
        OFS_CONFIG_B: begin
          reg_rdata <= (mode == MODE_CONFIG) ?
            {1'b0, interrupt_line_level, cfg_irq_select,
             cfg_dma_select} : 8'h00; // R5 R20
        end
        OFS_EXT_CONTROL: begin
          reg_rdata <= {mode, 1'b0, dma_request_enable,
                        service_interrupt_flag, fifo_full,
                        fifo_empty}; // R24
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end
  end

  // Link engine: forward strobe handshake, turnaround, reverse receive
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      link_state <= LK_IDLE;
      link_byte <= 8'h00;
      strobe_n <= 1'b1;
      flow_n <= 1'b1;
      init_n <= 1'b1;
      reversed <= 1'b0;
      setup_cnt <= 8'h00;
    end else begin
      case (link_state)
        LK_IDLE: begin
          if (eng_pop) begin
            link_byte <= fifo_out_data[7:0]; // R1
            flow_n <= ~fifo_out_data[8]; // R9
            setup_cnt <= 8'(SETUP_CYCLES);
            link_state <= LK_SETUP;
          end else if (proto_mode && dir_in) begin
            init_n <= 1'b0; // R13
            link_state <= LK_REV_TURN;
          end
        end
        LK_SETUP: begin
          if (setup_cnt != 8'h00) begin
            setup_cnt <= setup_cnt - 8'h01;
          end else if (!pin_in[IN_BUSY]) begin
            strobe_n <= 1'b0; // R7 R8
            link_state <= LK_STROBE;
          end
        end
        LK_STROBE: begin
          if (pin_in[IN_BUSY]) begin
            strobe_n <= 1'b1; // R7
            link_state <= LK_IDLE;
          end
        end
        LK_REV_TURN: begin
          if (!pin_in[IN_REVERSE_ACKNOWLEDGE_LINE]) begin
            reversed <= 1'b1; // R14
            flow_n <= 1'b0; // R10
            link_state <= LK_REV_WAIT;
          end
        end
        LK_REV_WAIT: begin
          if (!dir_in) begin
            flow_n <= 1'b1;
            init_n <= 1'b1; // R13
            link_state <= LK_FWD_TURN;
          end else if (!pin_in[IN_PERIPH_CLOCK_LINE]) begin
            flow_n <= 1'b1; // R10 R11
            link_state <= LK_REV_DONE;
          end
        end
        LK_REV_DONE: begin
          if (pin_in[IN_PERIPH_CLOCK_LINE] && rep_left == 8'h00) begin
            if (dir_in) begin
              flow_n <= 1'b0; // R10
              link_state <= LK_REV_WAIT;
            end else begin
              init_n <= 1'b1; // R13
              link_state <= LK_FWD_TURN;
            end
          end
        end
        LK_FWD_TURN: begin
          if (pin_in[IN_REVERSE_ACKNOWLEDGE_LINE]) begin
            reversed <= 1'b0; // R15
            link_state <= LK_IDLE;
          end
        end
        default: begin
          link_state <= LK_IDLE;
        end
      endcase
    end
  end

  // Reverse byte capture with run-length expansion into the FIFO
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rle_count <= 7'h00;
      rle_pending <= 1'b0;
      rep_left <= 8'h00;
      push_word <= 9'h000;
    end else if (link_state == LK_REV_WAIT && dir_in &&
                 !pin_in[IN_PERIPH_CLOCK_LINE]) begin
      if (!pin_in[IN_BUSY] && !pin_in[ADDR_TAG_BIT]) begin
        rle_count <= pin_in[6:0]; // R4
        rle_pending <= 1'b1;
      end else begin
        push_word <= {~pin_in[IN_BUSY], pin_in[7:0]}; // R12
        rep_left <= (rle_pending && pin_in[IN_BUSY]) ?
                    ({1'b0, rle_count} + 8'h01) : 8'h01; // R4
        rle_pending <= 1'b0;
      end
    end else if (rep_left != 8'h00 && fifo_in_ready) begin
      rep_left <= rep_left - 8'h01;
    end
  end

  // Registered pin drive
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pd_out <= 8'h00;
      pd_oe_n <= 1'b1;
      host_clock_strobe <= 1'b1;
      host_flow_line <= 1'b1;
      reverse_request_line <= 1'b0;
      select_in_line <= 1'b1;
      error_interrupt <= 1'b0;
    end else begin
      pd_out <= (proto_mode || mode == MODE_COMPAT_FIFO) ?
                link_byte : data_latch; // R7
      pd_oe_n <= reversed || dir_in; // R15 R16 R22
      if (proto_mode) begin
        host_clock_strobe <= strobe_n;
        host_flow_line <= flow_n; // R9 R10
        reverse_request_line <= init_n; // R13
        select_in_line <= 1'b1; // R6
      end else begin
        host_clock_strobe <= (mode == MODE_COMPAT_FIFO) ?
          strobe_n : ~control[CTL_STROBE_BIT]; // R3
        host_flow_line <= ~control[CTL_AUTOFD_BIT];
        reverse_request_line <= control[CTL_INIT_BIT];
        select_in_line <= ~control[CTL_SELECT_BIT];
      end
      error_interrupt <= proto_mode && !reversed &&
                         !pin_in[IN_FAULT]; // R17 R18
    end
  end
endmodule
`default_nettype wire

// File: pkg/ecpl_pkg.sv
// Constants shared by the extended-capabilities parallel port logic
package ecpl_pkg;
  localparam int ECPL_WORD_BITS = 8;
  localparam int ECPL_FIFO_DEPTH = 16;
  localparam int ECPL_ADDR_BITS = 11;

  localparam logic [10:0] OFS_DATA = 11'h000;
  localparam logic [10:0] OFS_STATUS = 11'h001;
  localparam logic [10:0] OFS_CONTROL = 11'h002;
  localparam logic [10:0] OFS_FIFO = 11'h400;
  localparam logic [10:0] OFS_CONFIG_B = 11'h401;
  localparam logic [10:0] OFS_EXT_CONTROL = 11'h402;

  localparam logic [2:0] MODE_STANDARD = 3'h0;
  localparam logic [2:0] MODE_BIDIR = 3'h1;
  localparam logic [2:0] MODE_COMPAT_FIFO = 3'h2;
  localparam logic [2:0] MODE_PROTOCOL = 3'h3;
  localparam logic [2:0] MODE_ENHANCED = 3'h4;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CONFIG = 3'h7;

  localparam int CTL_STROBE_BIT = 0;
  localparam int CTL_AUTOFD_BIT = 1;
  localparam int CTL_INIT_BIT = 2;
  localparam int CTL_SELECT_BIT = 3;
  localparam int CTL_ACKINT_BIT = 4;
  localparam int CTL_DIR_BIT = 5;
  localparam int ECR_MODE_LSB = 5;
  localparam int ECR_DMA_BIT = 3;
  localparam int ECR_SERVICE_BIT = 2;
  localparam int ADDR_TAG_BIT = 7;

  localparam logic [7:0] CONFIG_A_VALUE = 8'h10;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [5:0] CONTROL_RESET = 6'h00;
  localparam logic [2:0] MODE_RESET = 3'h0;

  // Synchronised input vector: data bits then the status lines
  localparam int IN_PERIPH_CLOCK_LINE = 8;
  localparam int IN_BUSY = 9;
  localparam int IN_REVERSE_ACKNOWLEDGE_LINE = 10;
  localparam int IN_FAULT = 11;
  localparam int IN_SELECT = 12;
  localparam int IN_BITS = 13;
  localparam logic [12:0] PIN_IN_RESET = 13'h1F00;

  localparam int CLK_PERIOD_NS = 50;
  localparam int DATA_SETUP_NS = 500;
  localparam int SETUP_RAW = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYCLES = (SETUP_RAW < 1) ? 1 : SETUP_RAW;
endpackage

// File: tb/ecpl_periph_model.sv
// Behavioural peripheral on the parallel cable side
`timescale 1ns/1ps
`default_nettype none
module ecpl_periph_model (
  input wire logic mclk,
  input wire logic [7:0] pd_out,
  input wire logic pd_oe_n,
  input wire logic host_clock_strobe,
  input wire logic host_flow_line,
  input wire logic reverse_request_line,
  input wire logic [5:0] stall,
  output logic [7:0] pd_in,
  output logic periph_clock_line,
  output logic periph_flow_line,
  output logic reverse_acknowledge_line
);
  logic [8:0] fwd_q[$];
  logic [8:0] rev_q[$];
  logic [7:0] drv = 8'h00;
  logic drv_on = 1'b0;

  // Released lines show the inverse of the last byte
  assign pd_in = !pd_oe_n ? pd_out : (drv_on ? drv : ~drv);

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  initial begin
    periph_clock_line = 1'b1;
    periph_flow_line = 1'b0;
    reverse_acknowledge_line = 1'b1;
    forever begin
      tick(1);
      if (!reverse_request_line) begin
        if (reverse_acknowledge_line) begin
          tick(stall);
          reverse_acknowledge_line = 1'b0;
        end else if (!host_flow_line && rev_q.size() > 0) begin
          {periph_flow_line, drv} = rev_q.pop_front();
          drv_on = 1'b1;
          tick(stall + 1);
          periph_clock_line = 1'b0;
          while (!host_flow_line) tick(1);
          periph_clock_line = 1'b1;
          drv_on = 1'b0;
        end
      end else if (!reverse_acknowledge_line) begin
        tick(stall);
        reverse_acknowledge_line = 1'b1;
        periph_flow_line = 1'b0;
      end else if (!host_clock_strobe) begin
        fwd_q.push_back({host_flow_line, pd_out});
        tick(stall);
        periph_flow_line = 1'b1;
        while (!host_clock_strobe) tick(1);
        tick(stall);
        periph_flow_line = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/ecpl_port_properties.sv
// Pin and register port properties of the parallel port block
`timescale 1ns/1ps
`default_nettype none
module ecpl_port_properties
  import ecpl_pkg::*;
#(
  parameter int FIFO_DEPTH = ECPL_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [10:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] pd_out,
  input wire logic pd_oe_n,
  input wire logic host_clock_strobe,
  input wire logic host_flow_line,
  input wire logic reverse_request_line,
  input wire logic select_in_line,
  input wire logic periph_clock_line,
  input wire logic periph_flow_line,
  input wire logic reverse_acknowledge_line,
  input wire logic peripheral_request_line,
  input wire logic error_interrupt
);
  logic [2:0] mode_q;
  logic dir_q;
  logic [2:0] pcnt;
  logic [2:0] fcnt;
  logic fwd_now;
  logic proto_ok;
  logic fwd_ok;
  logic rev_ok;

  // Mirror of mode and direction as written by the host
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      mode_q <= MODE_RESET;
    else if (reg_wr && reg_addr == OFS_EXT_CONTROL)
      mode_q <= reg_wdata[7:5];
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      dir_q <= 1'b0;
    else if (reg_wr && reg_addr == OFS_CONTROL)
      dir_q <= reg_wdata[CTL_DIR_BIT];
  end
  // Cycles spent in protocol mode and in a forward mode, saturating at 7
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      pcnt <= 3'h0;
    else if (mode_q != MODE_PROTOCOL)
      pcnt <= 3'h0;
    else if (pcnt != 3'h7)
      pcnt <= pcnt + 3'h1;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      fcnt <= 3'h0;
    else if (!fwd_now)
      fcnt <= 3'h0;
    else if (fcnt != 3'h7)
      fcnt <= fcnt + 3'h1;
  end
  assign fwd_now = mode_q == MODE_COMPAT_FIFO ||
                   (mode_q == MODE_PROTOCOL && !dir_q);
  assign proto_ok = pcnt == 3'h7 && mode_q == MODE_PROTOCOL;
  assign fwd_ok = fcnt == 3'h7 && fwd_now;
  assign rev_ok = proto_ok && dir_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_select_in_high: assert property (proto_ok |-> select_in_line)
    else $error("select-in asserted in protocol mode");
  a_drive_after_ack: assert property (proto_ok && $fell(pd_oe_n) |->
    reverse_request_line && $past(reverse_acknowledge_line, 3))
    else $error("data driven before channel returned forward");
  a_rev_no_drive: assert property (proto_ok && !reverse_request_line
    |-> pd_oe_n)
    else $error("data driven while reverse requested");
  a_strobe_data_hold: assert property (fwd_ok && !host_clock_strobe &&
    $past(!host_clock_strobe) |-> $stable(pd_out) &&
    $stable(host_flow_line))
    else $error("data or tag moved during strobe");
  a_strobe_needs_ready: assert property (fwd_ok && $fell(host_clock_strobe)
    |-> !$past(periph_flow_line, 4) && !pd_oe_n)
    else $error("strobe without ready or driven data");
  a_strobe_release: assert property (fwd_ok && !host_clock_strobe &&
    $rose(periph_flow_line) |-> ##[1:8] host_clock_strobe)
    else $error("strobe not released after busy");
  a_rev_flow_release: assert property (rev_ok && $fell(periph_clock_line)
    |-> ##[1:8] host_flow_line)
    else $error("reverse byte not acknowledged");
  a_fault_error: assert property ((proto_ok && reverse_request_line &&
    !peripheral_request_line)[*6] |-> error_interrupt)
    else $error("request line did not raise error");
  a_error_quiet: assert property (mode_q != MODE_PROTOCOL &&
    $past(mode_q) != MODE_PROTOCOL |-> !error_interrupt)
    else $error("error raised outside protocol mode");
  a_status_low_zero: assert property ($past(reg_rd) &&
    $past(reg_addr) == OFS_STATUS |-> reg_rdata[2:0] == 3'h0)
    else $error("status low bits not zero");
  a_config_a_value: assert property ($past(reg_rd) && $past(reg_addr) ==
    OFS_FIFO && $past(mode_q) == MODE_CONFIG |->
    reg_rdata == CONFIG_A_VALUE)
    else $error("config A value wrong");

  c_strobe: cover property (fwd_ok && $fell(host_clock_strobe));
  c_rev_byte: cover property (rev_ok && $fell(periph_clock_line));
  c_error: cover property ($rose(error_interrupt));
endmodule

bind ecpl_port ecpl_port_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.*);
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the parallel port block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ecpl_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [10:0] reg_addr = 11'h000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic preq_n = 1'b1;
  logic [5:0] stall = 6'h00;
  logic [2:0] irq_sel = 3'h5;
  logic [2:0] dma_sel = 3'h3;
  logic ilvl = 1'b1;
  logic sel_st = 1'b1;
  logic [7:0] reg_rdata, pd_in, pd_out;
  logic pd_oe_n, strobe, flow, rev_req, sel_in, pclk, busy, rack, err;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  int i;
  int k;

  always #25 mclk = ~mclk;

  ecpl_port u_ecpl_port (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .cfg_irq_select(irq_sel), .cfg_dma_select(dma_sel),
    .interrupt_line_level(ilvl), .pd_in(pd_in), .pd_out(pd_out),
    .pd_oe_n(pd_oe_n), .host_clock_strobe(strobe), .host_flow_line(flow),
    .reverse_request_line(rev_req), .select_in_line(sel_in),
    .periph_clock_line(pclk), .periph_flow_line(busy),
    .reverse_acknowledge_line(rack), .peripheral_request_line(preq_n),
    .select_status_line(sel_st), .error_interrupt(err)
  );
  ecpl_periph_model u_ecpl_periph_model (
    .mclk(mclk), .pd_out(pd_out), .pd_oe_n(pd_oe_n),
    .host_clock_strobe(strobe), .host_flow_line(flow),
    .reverse_request_line(rev_req), .stall(stall), .pd_in(pd_in),
    .periph_clock_line(pclk), .periph_flow_line(busy),
    .reverse_acknowledge_line(rack)
  );

  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    idle(1);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    idle(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [10:0] a, input logic [7:0] m,
                    input logic [7:0] e, input string n);
    idle(1);
    reg_addr = a;
    reg_rd = 1'b1;
    idle(1);
    reg_rd = 1'b0;
    chk(n, {1'b0, e}, {1'b0, reg_rdata & m});
  endtask
  task automatic wait_fwd(input int n);
    k = 0;
    while (u_ecpl_periph_model.fwd_q.size() < n && k < 4000) begin
      @(posedge mclk);
      k++;
    end
    #2;
  endtask
  task automatic stop_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test;
    end
  end

  initial begin
    idle(20);
    resetn = 1'b1;
    rd(OFS_CONTROL, 8'hFF, 8'h00, "control");
    rd(OFS_EXT_CONTROL, 8'hEB, 8'h01, "ecr");
    wr(OFS_CONTROL, 8'hC4);
    wr(OFS_DATA, 8'h96);
    idle(8);
    rd(OFS_CONTROL, 8'hFF, 8'h04, "control");
    rd(OFS_STATUS, 8'hFF, 8'hF8, "status");
    rd(OFS_DATA, 8'hFF, 8'h96, "data");
    $display("test registers done");
    wr(OFS_EXT_CONTROL, 8'hE0);
    rd(OFS_FIFO, 8'hFF, 8'h10, "config_a");
    rd(OFS_CONFIG_B, 8'hFF, 8'h6B, "config_b");
    rd(OFS_STATUS, 8'hFF, 8'hF8, "status");
    $display("test config done");
    wr(OFS_EXT_CONTROL, 8'hC0);
    for (i = 0; i < 17; i++) wr(OFS_FIFO, 8'h30 + i[7:0]);
    rd(OFS_EXT_CONTROL, 8'h03, 8'h02, "full");
    for (i = 0; i < 16; i++) rd(OFS_FIFO, 8'hFF, 8'h30 + i[7:0], "test_fifo_port");
    rd(OFS_EXT_CONTROL, 8'h03, 8'h01, "empty");
    rd(OFS_FIFO, 8'hFF, 8'h3F, "reread");
    $display("test fifo done");
    wr(OFS_CONTROL, 8'h24);
    stall = 6'd40;
    wr(OFS_EXT_CONTROL, 8'h40);
    for (i = 0; i < 18; i++) wr(OFS_FIFO, 8'hA0 + i[7:0]);
    rd(OFS_EXT_CONTROL, 8'h03, 8'h02, "full");
    wait_fwd(17);
    stall = 6'd0;
    for (i = 0; i < 17; i++)
      chk("compat", {1'b0, 8'hA0 + i[7:0]},
          {1'b0, u_ecpl_periph_model.fwd_q[i][7:0]});
    u_ecpl_periph_model.fwd_q.delete();
    $display("test compat done");
    wr(OFS_CONTROL, 8'h04);
    wr(OFS_EXT_CONTROL, 8'h60);
    wr(OFS_DATA, 8'h85);
    wr(OFS_FIFO, 8'h5A);
    wait_fwd(2);
    chk("addr", 9'h085, u_ecpl_periph_model.fwd_q[0]);
    chk("fdata", 9'h15A, u_ecpl_periph_model.fwd_q[1]);
    chk("sel_in", 9'h001, {8'h00, sel_in});
    chk("rev_req", 9'h001, {8'h00, rev_req});
    preq_n = 1'b0;
    idle(10);
    chk("err", 9'h001, {8'h00, err});
    preq_n = 1'b1;
    idle(8);
    chk("err", 9'h000, {8'h00, err});
    $display("test forward done");
    u_ecpl_periph_model.rev_q.push_back(9'h002);
    u_ecpl_periph_model.rev_q.push_back(9'h177);
    u_ecpl_periph_model.rev_q.push_back(9'h133);
    stall = 6'd3;
    wr(OFS_CONTROL, 8'h24);
    k = 0;
    while (u_ecpl_periph_model.rev_q.size() > 0 && k < 4000) begin
      @(posedge mclk);
      k++;
    end
    idle(16);
    chk("rev_req", 9'h000, {8'h00, rev_req});
    chk("oe_n", 9'h001, {8'h00, pd_oe_n});
    for (i = 0; i < 3; i++) rd(OFS_FIFO, 8'hFF, 8'h77, "rdata");
    rd(OFS_FIFO, 8'hFF, 8'h33, "rdata");
    rd(OFS_EXT_CONTROL, 8'h03, 8'h01, "empty");
    wr(OFS_CONTROL, 8'h04);
    idle(20);
    chk("rev_req", 9'h001, {8'h00, rev_req});
    chk("oe_n", 9'h000, {8'h00, pd_oe_n});
    $display("test reverse done");
    stop_test;
  end
endmodule
`default_nettype wire
